// file: hdl/quad_uart_host_bus_port.sv
// host bus port, register file and channel pin conventions
// Overview of operation
// - address bits 3:0 pick one of 16 channel registers, bits 5:4 the channel.
// - address bit 7 routes the access to the global registers.
// - in strobe mode a falling read strobe reads the register onto the bus.
// - in strobe mode a write is captured on the rising edge of write strobe.
// - in strobe mode the active-low chip select enables the device.
// - in select mode the write-strobe pin is direction, 1 read, 0 write.
// - in select mode chip select is the single transfer strobe.
// - one active-low open-drain interrupt output covers all channels.
// - a global register shows interrupt status of all four channels.
// - transmit idles high in normal mode and low in infrared mode.
// - in infrared mode receive is inverted whatever the polarity feature bit.
// - request-to-send is a software output only, with no auto function.
// - clear-to-send is an input or, when enabled, gates transmit.
// - each channel keeps 64-byte transmit and receive buffers with levels.
// - data-set-ready is an input or, when enabled, gates like clear-to-send.
`timescale 1ns/1ps
module quad_uart_host_bus_port
  import uart_port_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // host bus
  input  wire logic                bus_mode,
  input  wire logic [7:0]          addr,
  input  wire logic                chip_sel_n,
  input  wire logic                read_strobe_n,
  input  wire logic                write_strobe_n,
  input  wire logic [7:0]          data_in,
  output logic      [7:0]          data_out,
  output logic                     data_oe,
  // shared interrupt, open drain
  output logic                     irq_out_n,
  output logic                     irq_oe,
  // channel pins
  input  wire logic [NUM_CHAN-1:0] serial_in_n,
  input  wire logic [NUM_CHAN-1:0] clear_send_in_n,
  input  wire logic [NUM_CHAN-1:0] set_ready_in_n,
  input  wire logic [NUM_CHAN-1:0] tx_bit,
  output logic      [NUM_CHAN-1:0] serial_out,
  output logic      [NUM_CHAN-1:0] request_send_out_n,
  output logic      [NUM_CHAN-1:0] rx_mark,
  output logic      [NUM_CHAN-1:0] tx_allowed,
  // buffer fill and drain from the serial side
  input  wire logic [NUM_CHAN-1:0] rx_push,
  input  wire logic [7:0]          rx_byte,
  input  wire logic [NUM_CHAN-1:0] tx_pop,
  output logic      [NUM_CHAN-1:0] tx_has_data,
  output logic      [7:0]          tx_byte_out
);

  typedef struct packed {
    bus_state_t                          st;
    logic [7:0]                          rd_data;
    logic                                drive;
    logic [NUM_CHAN-1:0][NUM_REGS-1:0][7:0] regs;
    logic [NUM_CHAN-1:0][LEVEL_W-1:0]    tx_lvl;
    logic [NUM_CHAN-1:0][LEVEL_W-1:0]    rx_lvl;
    logic [NUM_CHAN-1:0][5:0]            tx_wp;
    logic [NUM_CHAN-1:0][5:0]            tx_rp;
    logic [NUM_CHAN-1:0][5:0]            rx_wp;
    logic [NUM_CHAN-1:0][5:0]            rx_rp;
    logic [NUM_CHAN-1:0]                 irq_pend;
    logic [7:0]                          tx_out;
  } state_t;

  state_t s;
  state_t next_s;
  logic [7:0] tx_mem [NUM_CHAN][FIFO_DEPTH];
  logic [7:0] rx_mem [NUM_CHAN][FIFO_DEPTH];

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    return a[CHAN_SEL_LSB +: 2];
  endfunction

  function automatic logic [3:0] reg_of(input logic [7:0] a);
    return a[REG_SEL_LSB +: REG_SEL_W];
  endfunction

  // ****************************************
  // buffer arithmetic
  // ****************************************
  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    // wraps at the buffer depth by width alone
    return p + 6'h01;
  endfunction

  function automatic logic lvl_full(input logic [LEVEL_W-1:0] l);
    return l == LEVEL_W'(FIFO_DEPTH);
  endfunction

  function automatic logic lvl_empty(input logic [LEVEL_W-1:0] l);
    return l == '0;
  endfunction

  // one push and one pop in a cycle cancel, level unchanged
  function automatic logic [LEVEL_W-1:0] lvl_step(
    input logic [LEVEL_W-1:0] l,
    input logic               up,
    input logic               down
  );
    return l + LEVEL_W'(up) - LEVEL_W'(down);
  endfunction

  // ****************************************
  // bus strobe decode
  // ****************************************
  logic sel_read;
  logic sel_write;
  logic [1:0] ch;
  logic [3:0] rg;
  logic       is_global;

  always_comb begin
    if (bus_mode) begin
      sel_read  = !chip_sel_n && !read_strobe_n;
      sel_write = !chip_sel_n && !write_strobe_n;
    end else begin
      sel_read  = !chip_sel_n && write_strobe_n;
      sel_write = !chip_sel_n && !write_strobe_n;
    end
    ch        = chan_of(addr);
    rg        = reg_of(addr);
    is_global = addr[GLOBAL_BIT];
  end

  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] rd_val;
  logic [NUM_CHAN-1:0] irq_cause;

  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      irq_cause[c] = s.regs[c][OFS_IRQ_EN][0] && !lvl_empty(s.rx_lvl[c]);
    end
    rd_val = 8'h00;
    if (is_global) begin
      if (rg == OFS_IRQ_SRC)
        rd_val = {4'h0, s.irq_pend};
      else if (rg == OFS_GLOB_ID)
        rd_val = GLOBAL_ID_VAL;
    end else begin
      case (rg)
        OFS_TX_DATA:  rd_val = rx_mem[ch][s.rx_rp[ch]];
        OFS_IRQ_ID:   rd_val = {7'h00, !s.irq_pend[ch]};
        OFS_MODEM_ST: rd_val = {2'h0, !set_ready_in_n[ch],
                                !clear_send_in_n[ch], 4'h0};
        OFS_TX_LEVEL: rd_val = {1'b0, s.tx_lvl[ch]};
        OFS_RX_LEVEL: rd_val = {1'b0, s.rx_lvl[ch]};
        default:      rd_val = s.regs[ch][rg];
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************
  logic bus_end;
  logic do_write;
  logic do_pop_rx;

  always_comb begin
    next_s    = s;
    bus_end   = !sel_read && !sel_write;
    do_write  = 1'b0;
    do_pop_rx = 1'b0;
    case (s.st)
      IDLE: begin
        if (sel_read) begin
          next_s.st      = READ;
          next_s.rd_data = rd_val;
          next_s.drive   = 1'b1;
        end else if (sel_write) begin
          next_s.st = WRITE;
        end
      end
      READ: begin
        if (!sel_read) begin
          next_s.st    = IDLE;
          next_s.drive = 1'b0;
          // pop only once the read ends, so the byte on the bus stays put
          do_pop_rx    = !is_global && rg == OFS_TX_DATA;
        end
      end
      WRITE: begin
        if (bus_end) begin
          next_s.st = IDLE;
          do_write  = 1'b1;
        end
      end
      default: next_s.st = IDLE;
    endcase
    if (do_write && !is_global) begin
      if (rg == OFS_TX_DATA) begin
        // a write to a full buffer is dropped; the host reads the level
        if (!lvl_full(s.tx_lvl[ch]))
          next_s.tx_wp[ch] = ptr_inc(s.tx_wp[ch]);
      end else begin
        next_s.regs[ch][rg] = data_in;
      end
    end
    if (do_pop_rx && !lvl_empty(s.rx_lvl[ch]))
      next_s.rx_rp[ch] = ptr_inc(s.rx_rp[ch]);
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (rx_push[c] && !lvl_full(s.rx_lvl[c]))
        next_s.rx_wp[c] = ptr_inc(s.rx_wp[c]);
      if (tx_pop[c] && !lvl_empty(s.tx_lvl[c]) && tx_allowed[c])
        next_s.tx_rp[c] = ptr_inc(s.tx_rp[c]);
      // level counts track pointer motion, full uses the extra bit
      next_s.tx_lvl[c] = lvl_step(s.tx_lvl[c],
        next_s.tx_wp[c] != s.tx_wp[c],
        next_s.tx_rp[c] != s.tx_rp[c]);
      next_s.rx_lvl[c] = lvl_step(s.rx_lvl[c],
        next_s.rx_wp[c] != s.rx_wp[c],
        next_s.rx_rp[c] != s.rx_rp[c]);
      next_s.irq_pend[c] = irq_cause[c];
    end
    next_s.tx_out = tx_mem[ch][s.tx_rp[ch]];
    if (rst) begin
      next_s.st       = IDLE;
      next_s.rd_data  = REG_RESET;
      next_s.drive    = 1'b0;
      next_s.regs     = '0;
      next_s.tx_lvl   = '0;
      next_s.rx_lvl   = '0;
      next_s.tx_wp    = '0;
      next_s.tx_rp    = '0;
      next_s.rx_wp    = '0;
      next_s.rx_rp    = '0;
      next_s.irq_pend = '0;
      next_s.tx_out   = REG_RESET;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // buffer storage, written beside the pointer updates
  always_ff @(posedge clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (next_s.tx_wp[c] != s.tx_wp[c] && !rst)
        tx_mem[c][s.tx_wp[c]] <= data_in;
      if (next_s.rx_wp[c] != s.rx_wp[c] && !rst)
        rx_mem[c][s.rx_wp[c]] <= rx_byte;
    end
  end

  // ****************************************
  // pins
  // ****************************************
  always_comb begin
    data_out    = s.rd_data;
    // drive drops with the strobe itself, so the bus frees at once
    data_oe     = s.drive && sel_read;
    // constant low level; the enable alone does the signalling
    irq_out_n   = 1'b0;
    irq_oe      = |s.irq_pend;
    tx_byte_out = s.tx_out;
  end

  // ****************************************
  // serial pins
  // ****************************************
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      // idle level flips in infrared mode
      serial_out[c] = s.regs[c][OFS_FEATURE][FEATURE_CONTROL_REG_IR_BIT]
                      ? tx_bit[c] : !tx_bit[c];
      // polarity bit 0: low is mark; bit 1: high is space, so low is mark
      rx_mark[c] = s.regs[c][OFS_FEATURE][FEATURE_CONTROL_REG_IR_BIT]
                   ? (s.regs[c][OFS_FEATURE][FEATURE_CONTROL_REG_RXPOL]
                      ? !serial_in_n[c] : !serial_in_n[c])
                   : serial_in_n[c];
    end
  end

  // ****************************************
  // modem pins and transmit gating
  // ****************************************
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      request_send_out_n[c] = !s.regs[c][OFS_MODEM_CTL][MCR_RTS_BIT];
      tx_allowed[c] = !s.regs[c][OFS_ENH_FEAT][EFR_AUTO_CTS]
                      || (!clear_send_in_n[c]
                          && !set_ready_in_n[c]);
    end
  end

  // ****************************************
  // buffer status
  // ****************************************
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      tx_has_data[c] = !lvl_empty(s.tx_lvl[c]);
    end
  end

endmodule

// file: pkg/uart_port_pkg.sv
// constants for the quad serial device host bus port
package uart_port_pkg;
  // ****************************************
  // address decode
  // ****************************************
  localparam int REG_SEL_LSB  = 0;
  localparam int REG_SEL_W    = 4;
  localparam int CHAN_SEL_LSB = 4;
  localparam int CHAN_SEL_W   = 3;
  localparam int GLOBAL_BIT   = 7;
  localparam int NUM_CHAN     = 4;
  localparam int NUM_REGS     = 16;
  localparam int NUM_GLOBAL   = 16;
  localparam int FIFO_DEPTH   = 64;
  localparam int LEVEL_W      = 7;
  // ****************************************
  // channel register offsets
  // ****************************************
  localparam logic [3:0] OFS_TX_DATA   = 4'h0;
  localparam logic [3:0] OFS_IRQ_EN    = 4'h1;
  localparam logic [3:0] OFS_IRQ_ID    = 4'h2;
  localparam logic [3:0] OFS_MODEM_CTL = 4'h4;
  localparam logic [3:0] OFS_MODEM_ST  = 4'h6;
  localparam logic [3:0] OFS_TX_LEVEL  = 4'h8;
  localparam logic [3:0] OFS_RX_LEVEL  = 4'h9;
  localparam logic [3:0] OFS_FEATURE   = 4'hA;
  localparam logic [3:0] OFS_ENH_FEAT  = 4'hB;
  // ****************************************
  // global register offsets, channel register fields and other constants
  // ****************************************
  localparam logic [3:0] OFS_IRQ_SRC   = 4'h0;
  localparam logic [3:0] OFS_GLOB_ID   = 4'hF;
  // arbitrary identification value
  localparam logic [7:0] GLOBAL_ID_VAL = 8'h5A;
  localparam int MCR_RTS_BIT   = 1;
  localparam int FEATURE_CONTROL_REG_RXPOL    = 4;
  localparam int FEATURE_CONTROL_REG_IR_BIT   = 6;
  localparam int EFR_AUTO_CTS  = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic [1:0] {IDLE, READ, WRITE} bus_state_t;
endpackage

// file: testbench/quad_uart_host_bus_port_assertions.sv
// bus port assertions
`timescale 1ns/1ps
module host_port_checks
  import uart_port_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                bus_mode,
  input wire logic                chip_sel_n,
  input wire logic                read_strobe_n,
  input wire logic                write_strobe_n,
  input wire logic [7:0]          data_out,
  input wire logic                data_oe,
  input wire logic                irq_out_n,
  input wire logic                irq_oe,
  input wire logic [NUM_CHAN-1:0] request_send_out_n,
  input wire logic [NUM_CHAN-1:0] clear_send_in_n,
  input wire logic [NUM_CHAN-1:0] set_ready_in_n,
  input wire logic [NUM_CHAN-1:0] tx_allowed
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_oe_sel; data_oe |-> !chip_sel_n; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("bus driven unselected");
  property p_oe_dir;
    data_oe |-> (bus_mode ? !read_strobe_n : write_strobe_n);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("bus driven on write");
  property p_rd_ans;
    bus_mode && !chip_sel_n && !read_strobe_n && $past(read_strobe_n)
      |=> data_oe;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_sel_ans;
    !bus_mode && !chip_sel_n && write_strobe_n && $past(chip_sel_n)
      |=> data_oe;
  endproperty
  a_sel_ans: assert property (p_sel_ans) else $error("no select read");
  property p_hold; data_oe && $past(data_oe) |-> $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("read byte moved");
  property p_od; !irq_out_n; endproperty
  a_od: assert property (p_od) else $error("interrupt driven high");
  property p_rst;
    $fell(rst) |-> &request_send_out_n && !irq_oe && !data_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_gate;
    (~clear_send_in_n & ~set_ready_in_n & ~tx_allowed) == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("transmit blocked");
endmodule
bind quad_uart_host_bus_port host_port_checks chk_u(.clk, .rst,
  .bus_mode, .chip_sel_n, .read_strobe_n, .write_strobe_n, .data_out,
  .data_oe, .irq_out_n, .irq_oe, .request_send_out_n, .clear_send_in_n,
  .set_ready_in_n, .tx_allowed);

// file: testbench/host_bus_model.sv
// host processor model on the parallel bus
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk,
  output logic            bus_mode,
  output logic [7:0]      addr,
  output logic            chip_sel_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  initial begin
    bus_mode = 1;
    addr = 8'h00;
    chip_sel_n = 1;
    read_strobe_n = 1;
    write_strobe_n = 1;
    data_in = 8'h00;
  end
  task acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk);
    addr = a;
    data_in = d;
    chip_sel_n = 0;
    if (bus_mode) begin
      read_strobe_n = w;
      write_strobe_n = !w;
    end else write_strobe_n = !w;
    repeat (2) @(negedge clk);
    q = data_oe ? data_out : 8'hXX;
    chip_sel_n = 1;
    read_strobe_n = 1;
    write_strobe_n = 1;
    // data held past the release edge
    @(negedge clk);
    data_in = ~d;
    @(negedge clk);
  endtask
endmodule

// file: testbench/test_quad_uart_host_bus_port.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
module test_quad_uart_host_bus_port;
  import uart_port_pkg::*;
  logic       clk = 0, rst = 1, bus_mode, chip_sel_n, read_strobe_n;
  logic       write_strobe_n, data_oe, irq_out_n, irq_oe;
  logic [7:0] addr, data_in, data_out, q, rx_byte = 8'h00, tx_byte_out;
  logic [3:0] serial_in_n = 4'hF, clear_send_in_n = 4'hF, tx_bit = 4'h0;
  logic [3:0] set_ready_in_n = 4'hF, rx_push = 4'h0, tx_pop = 4'h0;
  logic [3:0] serial_out, request_send_out_n, rx_mark, tx_allowed, tx_has_data;
  int n_errors = 0, comparisons = 0;
  always #25 clk = ~clk;
  quad_uart_host_bus_port dut_u(.clk, .rst, .bus_mode, .addr, .chip_sel_n,
    .read_strobe_n, .write_strobe_n, .data_in, .data_out, .data_oe,
    .irq_out_n, .irq_oe, .serial_in_n, .clear_send_in_n, .set_ready_in_n,
    .tx_bit, .serial_out, .request_send_out_n, .rx_mark, .tx_allowed,
    .rx_push, .rx_byte, .tx_pop, .tx_has_data, .tx_byte_out);
  host_bus_model host_u(.clk, .bus_mode, .addr, .chip_sel_n, .read_strobe_n,
    .write_strobe_n, .data_in, .data_out, .data_oe);
  task chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] a, exp); host_u.acc(0, a, 8'h00, q); chk(q, exp);
  endtask
  task wr(input logic [7:0] a, d); host_u.acc(1, a, d, q); endtask
  task print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task t_addr;
    chk({4'h0, request_send_out_n}, 8'h0F);
    for (int c = 0; c < 4; c++) begin
      wr({1'b0, 3'(c), OFS_MODEM_CTL}, 8'h02);
      chk({4'h0, request_send_out_n}, 8'h0F ^ (8'h01 << c));
      rd({1'b0, 3'(c), OFS_MODEM_CTL}, 8'h02);
      wr({1'b0, 3'(c), OFS_MODEM_CTL}, 8'h00);
    end
    wr(8'h8F, 8'h11);
    rd(8'h8F, GLOBAL_ID_VAL);
  endtask
  task t_select;
    host_u.bus_mode = 0;
    wr(8'h2A, 8'h50);
    rd(8'h2A, 8'h50);
    chk({7'h0, serial_out[2]}, 8'h00);
    serial_in_n[2] = 0;
    @(negedge clk);
    chk({7'h0, rx_mark[2]}, 8'h01);
    wr(8'h2A, 8'h00);
    chk({7'h0, serial_out[2]}, 8'h01);
    serial_in_n[2] = 1;
    tx_bit[2] = 1;
    @(negedge clk);
    chk({7'h0, serial_out[2]}, 8'h00);
    chk({7'h0, rx_mark[2]}, 8'h01);
    tx_bit[2] = 0;
    host_u.bus_mode = 1;
  endtask
  task t_irq;
    wr(8'h11, 8'h01);
    rx_byte = 8'hA5;
    rx_push = 4'h2;
    @(negedge clk);
    rx_push = 4'h0;
    @(negedge clk);
    chk({7'h0, irq_oe}, 8'h01);
    rd(8'h80, 8'h02);
    rd(8'h19, 8'h01);
    rd(8'h10, 8'hA5);
    @(negedge clk);
    chk({7'h0, irq_oe}, 8'h00);
  endtask
  task t_flow;
    wr(8'h3B, 8'h80);
    chk({4'h0, tx_allowed}, 8'h07);
    clear_send_in_n[3] = 0;
    @(negedge clk);
    chk({7'h0, tx_allowed[3]}, 8'h00);
    set_ready_in_n[3] = 0;
    @(negedge clk);
    chk({7'h0, tx_allowed[3]}, 8'h01);
    wr(8'h00, 8'h3C);
    chk({7'h0, tx_has_data[0]}, 8'h01);
    chk(tx_byte_out, 8'h3C);
    rd(8'h08, 8'h01);
    tx_pop = 4'h1;
    @(negedge clk);
    tx_pop = 4'h0;
    @(negedge clk);
    chk({7'h0, tx_has_data[0]}, 8'h00);
  endtask
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    t_addr();
    t_select();
    t_irq();
    t_flow();
    print_verdict();
  end
endmodule
